/* inc/xnor_chain_map.svh */
// constants for the pad connectivity chain: pad counts, bit positions, reset values
`ifndef XNOR_CHAIN_MAP_SVH
`define XNOR_CHAIN_MAP_SVH

// ----------------------------------------------------------------
// pad counts
// ----------------------------------------------------------------
// digital pads of the serial, parallel, keyboard and gpio portion
`define CHAIN_SIO_PADS 16
// digital pads of the hardware monitor (fan pwm, tach inputs)
`define CHAIN_HWM_PADS 8
// bus pads that join the chain once the mode is active
`define CHAIN_LPC_PADS 2
// total length of the cascade
`define CHAIN_LEN (`CHAIN_SIO_PADS + `CHAIN_HWM_PADS + `CHAIN_LPC_PADS)

// ----------------------------------------------------------------
// bit positions of the bus pads inside the cascade vector
// ----------------------------------------------------------------
`define CHAIN_POS_LAD0   0
`define CHAIN_POS_LFRAME 1

// ----------------------------------------------------------------
// reset values and synchroniser depth
// ----------------------------------------------------------------
`define HOST_RESET_SYNC_RST 1'h0
`define LPC_SYNC_RST        1'h1
`define SYNC_STAGES         2

`endif

/* inc/xnor_chain_pkg.sv */
// types shared by the pad connectivity chain modules
package xnor_chain_pkg;

	// ----------------------------------------------------------------
	// operating mode of the pads
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		MODE_NORMAL = 1'b0,
		MODE_CHAIN  = 1'b1
	} mode_t;

endpackage

/* logic/chain_cascade.sv */
// combinational xnor cascade over every participating pad input
`timescale 1ns/1ps
`include "xnor_chain_map.svh"

module chain_cascade (
	input  wire logic [`CHAIN_LEN-1:0] chain_in,
	output logic                       chain_out
);

	// ----------------------------------------------------------------
	// cascade
	// ----------------------------------------------------------------
	logic [`CHAIN_LEN-1:0] stage;

	// first stage is the lowest pin itself
	assign stage[0] = chain_in[0];

	// one xnor per further pad; any single flip inverts the end of the chain
	genvar i;
	generate
		for (i = 1; i < `CHAIN_LEN; i = i + 1) begin : g_stage
			assign stage[i] = ~(stage[i-1] ^ chain_in[i]);
		end
	endgenerate

	// no clock on the path, so the pad tester sees the result within gate delay
	assign chain_out = stage[`CHAIN_LEN-1];

endmodule

/* logic/mode_capture.sv */
// samples the bus pads on the rising edge of the host bus reset
`timescale 1ns/1ps
`include "xnor_chain_map.svh"

module mode_capture (
	input  wire logic ref_clk_in,
	input  wire logic rst_in,
	input  wire logic host_reset_n_in,
	input  wire logic lframe_n_in,
	input  wire logic lad0_in,
	output logic      chain_mode_out,
	output logic      host_reset_rise_out,
	output logic      sampled_lframe_n_out,
	output logic      sampled_lad0_out
);

	// ----------------------------------------------------------------
	// synchronisers
	// ----------------------------------------------------------------
	logic [`SYNC_STAGES-1:0] host_reset_sync;
	logic                    host_reset_last;
	logic [`SYNC_STAGES-1:0] lframe_sync;
	logic [`SYNC_STAGES-1:0] lad0_sync;
	xnor_chain_pkg::mode_t   mode;
	xnor_chain_pkg::mode_t   next_mode;

	// all three pins come from the board; equal depth keeps them aligned at the edge
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			host_reset_sync <= {`SYNC_STAGES{`HOST_RESET_SYNC_RST}};
			host_reset_last <= `HOST_RESET_SYNC_RST;
			lframe_sync     <= {`SYNC_STAGES{`LPC_SYNC_RST}};
			lad0_sync       <= {`SYNC_STAGES{`LPC_SYNC_RST}};
		end else begin
			host_reset_sync <= {host_reset_sync[0], host_reset_n_in};
			host_reset_last <= host_reset_sync[1];
			lframe_sync     <= {lframe_sync[0], lframe_n_in};
			lad0_sync       <= {lad0_sync[0], lad0_in};
		end
	end

	assign host_reset_rise_out  = host_reset_sync[1] & ~host_reset_last;
	assign sampled_lframe_n_out = lframe_sync[1];
	assign sampled_lad0_out     = lad0_sync[1];

	// ----------------------------------------------------------------
	// mode decision
	// ----------------------------------------------------------------
	// only a reset release changes the mode; both pads low enters, any high leaves
	always_comb begin
		next_mode = mode;
		if (host_reset_rise_out) begin
			case ({sampled_lframe_n_out, sampled_lad0_out})
				2'h0:    next_mode = xnor_chain_pkg::MODE_CHAIN;
				default: next_mode = xnor_chain_pkg::MODE_NORMAL;
			endcase
		end
	end

	// core supply power-on reset always lands in normal mode
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode <= xnor_chain_pkg::MODE_NORMAL;
		end else begin
			mode <= next_mode;
		end
	end

	assign chain_mode_out = (mode == xnor_chain_pkg::MODE_CHAIN);

endmodule

/* logic/xnor_chain_board_test.sv */
// pad connectivity test mode: mode capture, pad isolation and chain output mux
// Overview of operation
// - in chain mode, any pad flip toggles output
// - chain mode disconnects functions, pads become inputs
// - both bus pads low at reset release enters
// - either bus pad high at reset release leaves
// - host bus reset stays out of chain
// - chain result drives serial port one transmit
// - no supply, analog, output or reset pads
// - entry pads join chain once mode entered
// - core power-on reset leaves chain mode
// - outside chain mode, pads never affect output
// - chain spans serial portion and hardware monitor
`timescale 1ns/1ps
`include "xnor_chain_map.svh"

module xnor_chain_board_test (
	input  wire logic                           ref_clk_in,
	input  wire logic                           rst_in,
	input  wire logic                           host_reset_n_in,
	input  wire logic                           lframe_n_in,
	input  wire logic                           lad0_in,
	input  wire logic [`CHAIN_SIO_PADS-1:0]     sio_pad_in,
	input  wire logic [`CHAIN_HWM_PADS-1:0]     hwm_pad_in,
	input  wire logic [`CHAIN_SIO_PADS-1:0]     sio_func_out_in,
	input  wire logic [`CHAIN_SIO_PADS-1:0]     sio_func_oe_in,
	input  wire logic [`CHAIN_HWM_PADS-1:0]     hwm_func_out_in,
	input  wire logic [`CHAIN_HWM_PADS-1:0]     hwm_func_oe_in,
	input  wire logic                           lad0_func_out_in,
	input  wire logic                           lad0_func_oe_in,
	input  wire logic                           func_serial_port1_transmit_in,
	output logic [`CHAIN_SIO_PADS-1:0]          sio_pad_out,
	output logic [`CHAIN_SIO_PADS-1:0]          sio_pad_oe_out,
	output logic [`CHAIN_HWM_PADS-1:0]          hwm_pad_out,
	output logic [`CHAIN_HWM_PADS-1:0]          hwm_pad_oe_out,
	output logic                                lad0_out,
	output logic                                lad0_oe_out,
	output logic [`CHAIN_SIO_PADS-1:0]          sio_core_in_out,
	output logic [`CHAIN_HWM_PADS-1:0]          hwm_core_in_out,
	output logic                                lframe_n_core_out,
	output logic                                lad0_core_out,
	output logic                                serial_port1_transmit_out,
	output logic                                chain_mode_out
);

	// ----------------------------------------------------------------
	// mode capture
	// ----------------------------------------------------------------
	logic chain_mode;
	logic host_reset_rise;
	logic sampled_lframe_n;
	logic sampled_lad0;

	// the host bus reset only times the sampling; it never enters the cascade
	mode_capture u_mode_capture (
		.ref_clk_in           (ref_clk_in),
		.rst_in               (rst_in),
		.host_reset_n_in      (host_reset_n_in),
		.lframe_n_in          (lframe_n_in),
		.lad0_in              (lad0_in),
		.chain_mode_out       (chain_mode),
		.host_reset_rise_out  (host_reset_rise),
		.sampled_lframe_n_out (sampled_lframe_n),
		.sampled_lad0_out     (sampled_lad0)
	);

	assign chain_mode_out = chain_mode;

	// ----------------------------------------------------------------
	// cascade input assembly
	// ----------------------------------------------------------------
	logic [`CHAIN_LEN-1:0] chain_vec;
	logic                  chain_result;

	// bit order follows pin order, lowest pin at bit zero; supplies, analog
	// monitor lines, the transmit pad and the host bus reset are never wired in
	assign chain_vec = {hwm_pad_in, sio_pad_in, lframe_n_in, lad0_in};

	// entry pads are raw pad levels here, so they count like any other pad
	// once the mode has been taken
	chain_cascade u_chain_cascade (
		.chain_in  (chain_vec),
		.chain_out (chain_result)
	);

	// ----------------------------------------------------------------
	// pad isolation
	// ----------------------------------------------------------------
	// every pad drive enable is forced off in chain mode so the tester owns
	// the wire; output data keeps its functional value, it is simply not driven
	genvar s;
	generate
		for (s = 0; s < `CHAIN_SIO_PADS; s = s + 1) begin : g_sio_pad
			assign sio_pad_out[s]     = sio_func_out_in[s];
			assign sio_pad_oe_out[s]  = sio_func_oe_in[s] & ~chain_mode;
			assign sio_core_in_out[s] = sio_pad_in[s] & ~chain_mode;
		end
		for (s = 0; s < `CHAIN_HWM_PADS; s = s + 1) begin : g_hwm_pad
			assign hwm_pad_out[s]     = hwm_func_out_in[s];
			assign hwm_pad_oe_out[s]  = hwm_func_oe_in[s] & ~chain_mode;
			assign hwm_core_in_out[s] = hwm_pad_in[s] & ~chain_mode;
		end
	endgenerate

	// bus pads: lad0 is two-way and must release; the core sees an idle bus
	assign lad0_out          = lad0_func_out_in;
	assign lad0_oe_out       = lad0_func_oe_in & ~chain_mode;
	assign lframe_n_core_out = lframe_n_in | chain_mode;
	assign lad0_core_out     = lad0_in & ~chain_mode;

	// ----------------------------------------------------------------
	// chain output mux
	// ----------------------------------------------------------------
	// the transmit pad is the single driven pad in chain mode; a register here
	// would need a running clock on the test board, so the path stays
	// combinational and outside the mode the cascade cannot reach the pad
	always_comb begin
		if (chain_mode) begin
			serial_port1_transmit_out = chain_result;
		end else begin
			serial_port1_transmit_out = func_serial_port1_transmit_in;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// a reset release with both entry pads seen low
	sequence s_entry_edge;
		host_reset_rise && !sampled_lframe_n && !sampled_lad0;
	endsequence

	// a reset release with either entry pad seen high
	sequence s_exit_edge;
		host_reset_rise && (sampled_lframe_n || sampled_lad0);
	endsequence

	// exactly one chain pad changed since the last sample, mode unchanged
	sequence s_single_flip;
		chain_mode && $stable(chain_mode)
			&& ($countones(chain_vec ^ $past(chain_vec)) == 1);
	endsequence

	// entry: chain mode on the next edge and still on the edge after unless a later release comes
	property p_enter_on_release;
		@(posedge ref_clk_in) disable iff (rst_in)
		s_entry_edge |=> chain_mode ##1 (chain_mode || host_reset_rise);
	endproperty
	a_enter_on_release: assert property (p_enter_on_release)
		else $error("chain mode not entered on reset release with pads low");

	// exit: normal mode on the edge after the release
	property p_exit_on_release;
		@(posedge ref_clk_in) disable iff (rst_in)
		s_exit_edge |=> !chain_mode;
	endproperty
	a_exit_on_release: assert property (p_exit_on_release)
		else $error("chain mode not left on reset release with a pad high");

	// the mode only moves on a reset release
	property p_mode_only_on_release;
		@(posedge ref_clk_in) disable iff (rst_in)
		!host_reset_rise |=> $stable(chain_mode);
	endproperty
	a_mode_only_on_release: assert property (p_mode_only_on_release)
		else $error("mode changed without a host bus reset release");

	// core power-on reset clears the mode, with no disable on purpose
	property p_por_exits;
		@(posedge ref_clk_in)
		rst_in |=> !chain_mode;
	endproperty
	a_por_exits: assert property (p_por_exits)
		else $error("chain mode survived core power-on reset");

	// a single pad flip inverts the transmit pad
	property p_single_flip_toggles;
		@(posedge ref_clk_in) disable iff (rst_in)
		s_single_flip |-> (serial_port1_transmit_out != $past(serial_port1_transmit_out));
	endproperty
	a_single_flip_toggles: assert property (p_single_flip_toggles)
		else $error("single chain pad change did not toggle transmit pad");

	// entry pads themselves toggle the output once inside the mode
	property p_lpc_pads_in_chain;
		@(posedge ref_clk_in) disable iff (rst_in)
		(chain_mode && $stable(chain_mode) && $stable(sio_pad_in)
			&& $stable(hwm_pad_in) && ($stable(lad0_in) != $stable(lframe_n_in)))
		|-> (serial_port1_transmit_out != $past(serial_port1_transmit_out));
	endproperty
	a_lpc_pads_in_chain: assert property (p_lpc_pads_in_chain)
		else $error("bus pad change in chain mode did not toggle output");

	// the host bus reset alone never moves the chain output
	property p_reset_not_in_chain;
		@(posedge ref_clk_in) disable iff (rst_in)
		(chain_mode && $stable(chain_mode) && $stable(chain_vec)
			&& !$stable(host_reset_n_in))
		|-> $stable(serial_port1_transmit_out);
	endproperty
	a_reset_not_in_chain: assert property (p_reset_not_in_chain)
		else $error("host bus reset reached the chain output");

	// in chain mode the transmit pad carries the cascade
	property p_transmit_is_chain;
		@(posedge ref_clk_in) disable iff (rst_in)
		chain_mode |-> (serial_port1_transmit_out == (^chain_vec ^ 1'h1));
	endproperty
	a_transmit_is_chain: assert property (p_transmit_is_chain)
		else $error("transmit pad does not carry the chain parity");

	// pads released and the core isolated for the whole mode
	property p_pads_released;
		@(posedge ref_clk_in) disable iff (rst_in)
		chain_mode |-> (sio_pad_oe_out == '0) && (hwm_pad_oe_out == '0)
			&& !lad0_oe_out && (sio_core_in_out == '0) && (hwm_core_in_out == '0);
	endproperty
	a_pads_released: assert property (p_pads_released)
		else $error("a pad is still driven or connected in chain mode");

	// outside the mode pad changes leave the transmit pad alone
	property p_no_effect_outside;
		@(posedge ref_clk_in) disable iff (rst_in)
		(!chain_mode && $stable(chain_mode) && !$stable(chain_vec)
			&& $stable(func_serial_port1_transmit_in))
		|-> $stable(serial_port1_transmit_out);
	endproperty
	a_no_effect_outside: assert property (p_no_effect_outside)
		else $error("chain pad change reached transmit pad in normal mode");

	// functional outputs return within one cycle of an exit edge
	property p_functions_back;
		@(posedge ref_clk_in) disable iff (rst_in)
		(chain_mode ##1 s_exit_edge) |=> (lad0_oe_out == lad0_func_oe_in)
			&& (serial_port1_transmit_out == func_serial_port1_transmit_in);
	endproperty
	a_functions_back: assert property (p_functions_back)
		else $error("functions not restored after leaving chain mode");

	// exit: normal mode on the next edge and still on the edge after unless a later release comes
	property p_exit_holds;
		@(posedge ref_clk_in) disable iff (rst_in)
		s_exit_edge |=> !chain_mode ##1 (!chain_mode || host_reset_rise);
	endproperty
	a_exit_holds: assert property (p_exit_holds)
		else $error("normal mode not held after leaving chain mode");

	// the bus core side sees an idle frame and a low data line for the whole mode
	property p_core_bus_idle;
		@(posedge ref_clk_in) disable iff (rst_in)
		chain_mode |-> lframe_n_core_out && !lad0_core_out;
	endproperty
	a_core_bus_idle: assert property (p_core_bus_idle)
		else $error("bus core inputs not idle in chain mode");

	// outside the mode every pad enable and core input follows the functions
	property p_normal_passthrough;
		@(posedge ref_clk_in) disable iff (rst_in)
		!chain_mode |-> (sio_pad_oe_out == sio_func_oe_in)
			&& (hwm_pad_oe_out == hwm_func_oe_in)
			&& (lad0_oe_out == lad0_func_oe_in) && (sio_core_in_out == sio_pad_in)
			&& (hwm_core_in_out == hwm_pad_in) && (lad0_core_out == lad0_in)
			&& (lframe_n_core_out == lframe_n_in);
	endproperty
	a_normal_passthrough: assert property (p_normal_passthrough)
		else $error("pad functions not connected in normal mode");

	// outside the mode the transmit pad carries the serial function
	property p_normal_transmit;
		@(posedge ref_clk_in) disable iff (rst_in)
		!chain_mode |-> (serial_port1_transmit_out == func_serial_port1_transmit_in);
	endproperty
	a_normal_transmit: assert property (p_normal_transmit)
		else $error("transmit pad lost its function in normal mode");

	// the release pulse lasts one cycle, so one pin edge gives one decision
	property p_rise_single;
		@(posedge ref_clk_in) disable iff (rst_in)
		host_reset_rise |=> !host_reset_rise;
	endproperty
	a_rise_single: assert property (p_rise_single)
		else $error("host bus reset release seen on two cycles");

	// chain mode held and only the monitor pads moved, exactly one of them
	sequence s_monitor_flip;
		chain_mode && $stable(chain_mode) && $stable(sio_pad_in) && $stable(lad0_in)
			&& $stable(lframe_n_in) && ($countones(hwm_pad_in ^ $past(hwm_pad_in)) == 1);
	endsequence

	// chain mode held and only the serial and io pads moved, exactly one of them
	sequence s_serial_io_flip;
		chain_mode && $stable(chain_mode) && $stable(hwm_pad_in) && $stable(lad0_in)
			&& $stable(lframe_n_in) && ($countones(sio_pad_in ^ $past(sio_pad_in)) == 1);
	endsequence

	// the hardware monitor pads are links of the cascade
	property p_monitor_in_chain;
		@(posedge ref_clk_in) disable iff (rst_in)
		s_monitor_flip |-> (serial_port1_transmit_out != $past(serial_port1_transmit_out));
	endproperty
	a_monitor_in_chain: assert property (p_monitor_in_chain)
		else $error("monitor pad change in chain mode did not toggle output");

	// the serial and io pads are links of the cascade
	property p_serial_io_in_chain;
		@(posedge ref_clk_in) disable iff (rst_in)
		s_serial_io_flip |-> (serial_port1_transmit_out != $past(serial_port1_transmit_out));
	endproperty
	a_serial_io_in_chain: assert property (p_serial_io_in_chain)
		else $error("serial or io pad change in chain mode did not toggle output");

endmodule

/* test/board_tester.sv */
// board test equipment model: drives the chain pads and the host bus reset pin
`timescale 1ns/1ps
`include "xnor_chain_map.svh"

module board_tester (
	input  wire logic                      ref_clk_in,
	output logic                           host_reset_n_out,
	output logic                           lframe_n_out,
	output logic                           lad0_out,
	output logic [`CHAIN_SIO_PADS-1:0]     sio_pad_out,
	output logic [`CHAIN_HWM_PADS-1:0]     hwm_pad_out,
	output logic [`CHAIN_LEN-1:0]          pads_out
);
	// ----------------------------------------------------------------
	// pad levels, chain order {hwm, sio, frame, data0}
	// ----------------------------------------------------------------
	logic [`CHAIN_LEN-1:0] pads;

	initial begin
		pads = '0;
		host_reset_n_out = 1'b0;
	end
	assign pads_out = pads;
	assign lad0_out = pads[`CHAIN_POS_LAD0];
	assign lframe_n_out = pads[`CHAIN_POS_LFRAME];
	assign sio_pad_out = pads[`CHAIN_SIO_PADS+1:2];
	assign hwm_pad_out = pads[`CHAIN_LEN-1:`CHAIN_SIO_PADS+2];

	// entry pads settle while reset is low and hold well past the rise
	task bus_release(input logic frame_n, input logic data0);
		@(posedge ref_clk_in);
		host_reset_n_out <= 1'b0;
		pads[`CHAIN_POS_LFRAME] <= frame_n;
		pads[`CHAIN_POS_LAD0] <= data0;
		repeat (3) @(posedge ref_clk_in);
		host_reset_n_out <= 1'b1;
		repeat (5) @(posedge ref_clk_in);
	endtask

	task host_reset_low;
		@(posedge ref_clk_in);
		host_reset_n_out <= 1'b0;
	endtask

	task set_pads(input logic [`CHAIN_LEN-1:0] vec);
		@(posedge ref_clk_in);
		pads <= vec;
	endtask

	// one pad a step: raise highest low pad, or lower lowest high pad
	task step(input logic up);
		int k;
		k = -1;
		for (int i = 0; i < `CHAIN_LEN; i++) begin
			if (up ? !pads[i] : (pads[i] && k < 0)) k = i;
		end
		@(posedge ref_clk_in);
		if (k >= 0) pads[k] <= up;
	endtask
endmodule

/* test/tb_top.sv */
// self-checking bench for the pad connectivity chain with a tester model
`timescale 1ns/1ps
`include "xnor_chain_map.svh"
`define CHECK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin \
	failures++; $display("mismatch %s expected %h seen %h", what, exp, got); end end

module tb_top;
	logic                          ref_clk_in = 1'b0;
	logic                          rst_in = 1'b1;
	logic                          host_reset_n, lframe_n, lad0, func_tx, lad0_fo, lad0_foe;
	logic [`CHAIN_SIO_PADS-1:0]    sio_pad, sio_fo = '0, sio_foe = '0, sio_po, sio_poe, sio_ci;
	logic [`CHAIN_HWM_PADS-1:0]    hwm_pad, hwm_fo = '0, hwm_foe = '0, hwm_po, hwm_poe, hwm_ci;
	logic [`CHAIN_LEN-1:0]         pads;
	logic                          lad0_po, lad0_poe, lframe_core, lad0_core, tx, mode;
	int                            failures = 0, total_checks = 0, exp_mode = 0;

	initial begin
		func_tx = 1'b0;
		lad0_fo = 1'b0;
		lad0_foe = 1'b0;
	end
	always #4 ref_clk_in = ~ref_clk_in;

	board_tester board_tester_i (.ref_clk_in(ref_clk_in), .host_reset_n_out(host_reset_n),
		.lframe_n_out(lframe_n), .lad0_out(lad0), .sio_pad_out(sio_pad),
		.hwm_pad_out(hwm_pad), .pads_out(pads));

	xnor_chain_board_test xnor_chain_board_test_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.host_reset_n_in(host_reset_n), .lframe_n_in(lframe_n), .lad0_in(lad0),
		.sio_pad_in(sio_pad), .hwm_pad_in(hwm_pad), .sio_func_out_in(sio_fo),
		.sio_func_oe_in(sio_foe), .hwm_func_out_in(hwm_fo), .hwm_func_oe_in(hwm_foe),
		.lad0_func_out_in(lad0_fo), .lad0_func_oe_in(lad0_foe),
		.func_serial_port1_transmit_in(func_tx), .sio_pad_out(sio_po),
		.sio_pad_oe_out(sio_poe), .hwm_pad_out(hwm_po), .hwm_pad_oe_out(hwm_poe),
		.lad0_out(lad0_po), .lad0_oe_out(lad0_poe), .sio_core_in_out(sio_ci),
		.hwm_core_in_out(hwm_ci), .lframe_n_core_out(lframe_core), .lad0_core_out(lad0_core),
		.serial_port1_transmit_out(tx), .chain_mode_out(mode));

	task results;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// reference model: parity counted bit by bit over the tester's pads
	task check_all;
		int   par;
		logic m;
		@(negedge ref_clk_in);
		m = (exp_mode != 0);
		par = 0;
		for (int i = 0; i < `CHAIN_LEN; i++) par = par ^ int'(pads[i]);
		`CHECK("mode", m, mode)
		`CHECK("tx", m ? ~par[0] : func_tx, tx)
		`CHECK("sio_oe", sio_foe & {`CHAIN_SIO_PADS{~m}}, sio_poe)
		`CHECK("hwm_oe", hwm_foe & {`CHAIN_HWM_PADS{~m}}, hwm_poe)
		`CHECK("lad0_oe", lad0_foe & ~m, lad0_poe)
		`CHECK("sio_ci", sio_pad & {`CHAIN_SIO_PADS{~m}}, sio_ci)
		`CHECK("hwm_ci", hwm_pad & {`CHAIN_HWM_PADS{~m}}, hwm_ci)
		`CHECK("lad0_ci", lad0 & ~m, lad0_core)
		`CHECK("frame_ci", lframe_n | m, lframe_core)
		`CHECK("pad_out", {sio_fo, hwm_fo, lad0_fo}, {sio_po, hwm_po, lad0_po})
	endtask

	// fresh functional drive from the core, then a full comparison
	task rand_func;
		@(posedge ref_clk_in);
		sio_fo <= `CHAIN_SIO_PADS'($urandom());
		sio_foe <= `CHAIN_SIO_PADS'($urandom());
		hwm_fo <= `CHAIN_HWM_PADS'($urandom());
		hwm_foe <= `CHAIN_HWM_PADS'($urandom());
		{lad0_fo, lad0_foe, func_tx} <= 3'($urandom());
		check_all;
	endtask

	// bounded wait for the mode flag to reach the model's mode
	task wait_mode;
		int n;
		n = 0;
		while (mode !== (exp_mode != 0) && n < 8) begin
			@(negedge ref_clk_in);
			n++;
		end
		if (mode !== (exp_mode != 0)) begin
			failures++;
			$display("mismatch mode_wait expected %0d seen %b", exp_mode, mode);
			results;
		end
	endtask

	task release_to(input logic frame_n, input logic data0);
		board_tester_i.bus_release(frame_n, data0);
		exp_mode = (frame_n == 1'b0 && data0 == 1'b0);
		wait_mode;
		rand_func;
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk_in);
		failures++;
		results;
	end

	initial begin
		void'($urandom(32'h6FADBC73));
		repeat (8) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		// normal mode: pads must never reach the transmit pad
		for (int i = 0; i < 8; i++) begin
			board_tester_i.set_pads(`CHAIN_LEN'($urandom()));
			rand_func;
		end
		release_to(1'b1, 1'b0);
		$display("test normal done");
		// entry with all pads low, then the full sweep up and back down
		board_tester_i.set_pads('0);
		release_to(1'b0, 1'b0);
		for (int i = 0; i < `CHAIN_LEN; i++) begin
			board_tester_i.step(1'b1);
			check_all;
		end
		for (int i = 0; i < `CHAIN_LEN; i++) begin
			board_tester_i.step(1'b0);
			check_all;
		end
		$display("test sweep done");
		// bus reset pin low must leave the chain output alone
		board_tester_i.host_reset_low;
		check_all;
		release_to(1'b0, 1'b0);
		for (int i = 0; i < 16; i++) begin
			board_tester_i.set_pads(`CHAIN_LEN'($urandom()));
			rand_func;
		end
		$display("test chain_random done");
		// every exit pattern, re-entering after each
		for (int p = 1; p < 4; p++) begin
			release_to(p[1], p[0]);
			board_tester_i.set_pads(`CHAIN_LEN'($urandom()));
			rand_func;
			release_to(1'b0, 1'b0);
		end
		$display("test exit done");
		// core power-on reset from chain mode, bus reset held low meanwhile
		board_tester_i.host_reset_low;
		@(posedge ref_clk_in);
		rst_in <= 1'b1;
		exp_mode = 0;
		check_all;
		@(posedge ref_clk_in);
		rst_in <= 1'b0;
		rand_func;
		$display("test power_on done");
		results;
	end
endmodule
